// File: dct_regs.svh
// Timing and field constants for the CKE reset and ODT timing block
`ifndef DCT_REGS_SVH
`define DCT_REGS_SVH
`define DCT_CLK_PERIOD_NS 8
`define DCT_TMOD_NS 12
`define DCT_TMOD_CYC ((`DCT_TMOD_NS + `DCT_CLK_PERIOD_NS - 1) / `DCT_CLK_PERIOD_NS)
`define DCT_TANPD_CYC 3
`define DCT_TAXPD_CYC 8
`define DCT_TAOND_CYC 2
`define DCT_TAOFD_CYC 2
`define DCT_TAPD_CYC 2
`define DCT_MR_SLOW_EXIT_BIT 12
`define DCT_EMR_RTT_HI_BIT 6
`define DCT_EMR_RTT_LO_BIT 2
`define DCT_BA_MR 2'h0
`define DCT_BA_EMR 2'h1
`define DCT_BURST_CYC 4
`endif

// File: dct_pkg.sv
// Types for the CKE reset and ODT timing block
`default_nettype none
package dct_pkg;
    typedef enum logic [1:0] {DCT_ODT_SYNC, DCT_ODT_ASYNC} dct_odt_mode_t;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [13:0] addr;
    } dct_cmd_t;
    typedef struct packed {
        logic term_on;
        logic [1:0] rtt;
        logic async_timing;
    } dct_odt_stat_t;
endpackage : dct_pkg
`default_nettype wire

// File: dct_cke_odt.sv
// DDR2 device-side CKE reset and ODT timing-mode selection
`timescale 1ns/1ns
`default_nettype none
`include "dct_regs.svh"
// Summary of operation
// - CKE low reset discards state, reinit recovers
// - In reset only CKE and MR loads are observed
// - Interrupted read may finish after CKE rises
// - ODT timing follows CKE and power mode
// - No ODT switching in self refresh or early
// - Active and fast-exit use synchronous timing
// - Slow-exit and precharge down use asynchronous
// - Turn-off before entry: sync if tANPD met
// - Turn-on before entry: sync if tANPD met
// - Turn-off after exit: sync after tAXPD
// - Turn-on after slow exit: sync after tAXPD
// - EMRS changes Rtt within tMOD maximum
// - EMR load updates Rtt from A6, A2
module dct_cke_odt
    import dct_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic odt,
    input wire dct_cmd_t cmd,
    input wire logic banks_open,
    input wire logic read_burst,
    output logic in_reset,
    output logic read_resume,
    output dct_odt_stat_t odt_stat,
    output logic odt_enabled
);
    typedef enum {ST_RESET, ST_ACTIVE, ST_PD_FAST, ST_PD_SLOW, ST_PD_PRE, ST_SELF_REF} dct_st_t;

    function automatic logic is_lm(input dct_cmd_t c);
        is_lm = !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;
    endfunction : is_lm

    function automatic logic is_ref(input dct_cmd_t c);
        is_ref = !c.cs_n && !c.ras_n && !c.cas_n && c.we_n;
    endfunction : is_ref

    dct_st_t state_r;
    logic cke_d_r;
    logic slow_exit_r;
    logic [1:0] rtt_r;
    logic [1:0] rtt_pend_r;
    logic [3:0] mod_cnt_r;
    logic [3:0] anpd_cnt_r;
    logic [3:0] axpd_cnt_r;
    logic [3:0] dly_cnt_r;
    logic odt_d_r;
    logic odt_target_r;
    logic odt_async_r;
    logic exit_async_r;
    logic burst_cut_r;
    logic init_seen_r;
    logic lm_emr;
    logic in_pd;
    logic pd_async;
    logic odt_edge;

    assign lm_emr = cke && cke_d_r && state_r == ST_ACTIVE && is_lm(cmd)
        && cmd.ba == `DCT_BA_EMR;
    assign in_pd = state_r == ST_PD_FAST || state_r == ST_PD_SLOW || state_r == ST_PD_PRE;
    assign pd_async = state_r == ST_PD_SLOW || state_r == ST_PD_PRE;
    assign odt_edge = odt != odt_d_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cke_d_r <= 1'b0;
        end else begin
            cke_d_r <= cke;
        end
    end

    // Power state; a CKE drop during an active read burst is a reset, left only after CKE high and an MR load
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= ST_RESET;
        end else begin
            case (state_r)
                ST_RESET: begin
                    if (cke && cke_d_r && init_seen_r) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!cke && cke_d_r) begin
                        if (is_ref(cmd)) begin
                            state_r <= ST_SELF_REF;
                        end else if (read_burst) begin
                            state_r <= ST_RESET;
                        end else if (!banks_open) begin
                            state_r <= ST_PD_PRE;
                        end else if (slow_exit_r) begin
                            state_r <= ST_PD_SLOW;
                        end else begin
                            state_r <= ST_PD_FAST;
                        end
                    end
                end
                ST_PD_FAST, ST_PD_SLOW, ST_PD_PRE, ST_SELF_REF: begin
                    if (cke) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                default: begin
                    state_r <= ST_RESET;
                end
            endcase
        end
    end

    // A reset is entered on a CKE drop during a read burst; init completes on the first MR load
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_r != ST_RESET) begin
            init_seen_r <= 1'b0;
        end else if (cke && is_lm(cmd) && cmd.ba == `DCT_BA_MR) begin
            init_seen_r <= 1'b1;
        end
    end

    // Read cut short by reset may complete when CKE returns
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            burst_cut_r <= 1'b0;
            dly_cnt_r <= 4'h0;
        end else if (state_r == ST_ACTIVE && !cke && read_burst) begin
            burst_cut_r <= 1'b1;
            dly_cnt_r <= 4'h0;
        end else if (state_r == ST_RESET && cke && burst_cut_r) begin
            if (dly_cnt_r == 4'(`DCT_BURST_CYC - 1)) begin
                burst_cut_r <= 1'b0;
            end
            dly_cnt_r <= dly_cnt_r + 4'h1;
        end
    end

    // Mode register capture: slow-exit select and Rtt
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            slow_exit_r <= 1'b0;
        end else if (cke && !cke_d_r ? 1'b0 : cke && is_lm(cmd) && cmd.ba == `DCT_BA_MR) begin
            slow_exit_r <= cmd.addr[`DCT_MR_SLOW_EXIT_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_r == ST_RESET) begin
            rtt_pend_r <= 2'h0;
            rtt_r <= 2'h0;
            mod_cnt_r <= 4'h0;
        end else if (lm_emr) begin
            rtt_pend_r <= {cmd.addr[`DCT_EMR_RTT_HI_BIT], cmd.addr[`DCT_EMR_RTT_LO_BIT]};
            mod_cnt_r <= 4'(`DCT_TMOD_CYC);
        end else if (mod_cnt_r != 4'h0) begin
            mod_cnt_r <= mod_cnt_r - 4'h1;
            if (mod_cnt_r == 4'h1) begin
                rtt_r <= rtt_pend_r;
            end
        end
    end

    // Counters since ODT change (for entry) and since power-down exit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            odt_d_r <= 1'b0;
            anpd_cnt_r <= 4'h0;
            axpd_cnt_r <= 4'h0;
            exit_async_r <= 1'b0;
        end else begin
            odt_d_r <= odt;
            if (odt_edge) begin
                anpd_cnt_r <= 4'h0;
            end else if (anpd_cnt_r != 4'hf) begin
                anpd_cnt_r <= anpd_cnt_r + 4'h1;
            end
            if (in_pd && cke) begin
                axpd_cnt_r <= 4'h0;
                // Turn-on after a fast exit stays synchronous
                exit_async_r <= pd_async;
            end else if (axpd_cnt_r != 4'hf) begin
                axpd_cnt_r <= axpd_cnt_r + 4'h1;
            end
        end
    end

    // ODT edge timing classification
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_r == ST_RESET) begin
            odt_target_r <= 1'b0;
            odt_async_r <= 1'b0;
        end else if (state_r == ST_SELF_REF || mod_cnt_r != 4'h0 || rtt_r == 2'h0) begin
            odt_target_r <= 1'b0;
            odt_async_r <= 1'b0;
        end else if (odt_edge) begin
            odt_target_r <= odt;
            if (in_pd) begin
                odt_async_r <= pd_async;
            end else if (!cke && cke_d_r) begin
                // Change coincides with entry, so no margin at all
                odt_async_r <= 1'b1;
            end else if (axpd_cnt_r < 4'(`DCT_TAXPD_CYC - 1)) begin
                // Counters hold pre-edge values, hence the limit minus one
                odt_async_r <= !odt || exit_async_r;
            end else begin
                odt_async_r <= 1'b0;
            end
        end else if (!cke && cke_d_r && anpd_cnt_r < 4'(`DCT_TANPD_CYC - 1) && state_r == ST_ACTIVE) begin
            odt_async_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_reset <= 1'b1;
            read_resume <= 1'b0;
            odt_stat <= '0;
            odt_enabled <= 1'b0;
        end else begin
            in_reset <= state_r == ST_RESET;
            read_resume <= state_r == ST_RESET && cke && burst_cut_r;
            // Gated so term_on and odt_enabled show nothing live in the cycle reset is entered
            odt_stat <= '{term_on: odt_target_r && state_r != ST_RESET, rtt: rtt_r,
                async_timing: odt_async_r};
            odt_enabled <= state_r != ST_RESET && rtt_r != 2'h0 && mod_cnt_r == 4'h0;
        end
    end
endmodule : dct_cke_odt
`default_nettype wire

// File: dct_cke_odt_props.sv
// Checker for the CKE reset and ODT timing block
`timescale 1ns/1ns
`default_nettype none
module dct_cke_odt_props
    import dct_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic odt,
    input wire dct_cmd_t cmd,
    input wire logic banks_open,
    input wire logic read_burst,
    input wire logic in_reset,
    input wire logic read_resume,
    input wire dct_odt_stat_t odt_stat,
    input wire logic odt_enabled
);
    logic [3:0] cke_hi_r;
    wire lm = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Saturates so long active stretches stay cheap
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !cke) cke_hi_r <= 4'h0;
        else if (cke_hi_r != 4'hf) cke_hi_r <= cke_hi_r + 4'h1;
    end
    a_rst_enter: assert property (disable iff (1'b0) sys_rst |=> in_reset)
        else $error("no reset state");
    a_read_cut: assert property (!in_reset && read_burst && $past(cke) && !cke |-> ##[1:2] in_reset)
        else $error("cut read no reset");
    a_rst_ignore: assert property (in_reset |-> !odt_stat.term_on && !odt_enabled)
        else $error("odt seen in reset");
    a_emr_rtt: assert property (!in_reset && cke && $past(cke) && lm && cmd.ba == 2'h1 |-> ##4
        odt_stat.rtt == {$past(cmd.addr[6], 4), $past(cmd.addr[2], 4)})
        else $error("rtt update wrong");
    a_en_rtt: assert property (odt_enabled |-> odt_stat.rtt != 2'h0)
        else $error("enabled with rtt zero");
    a_term_rtt: assert property (odt_stat.term_on |-> odt_stat.rtt != 2'h0)
        else $error("term with rtt zero");
    a_sync_act: assert property (cke_hi_r == 4'hf && $changed(odt_stat.term_on) |-> !odt_stat.async_timing)
        else $error("async in active");
    a_resume_len: assert property ($rose(read_resume) |-> read_resume[*4] ##1 !read_resume)
        else $error("resume length");
    cover property (odt_stat.async_timing);
    cover property ($fell(in_reset));
    cover property (odt_stat.term_on);
endmodule : dct_cke_odt_props
bind dct_cke_odt dct_cke_odt_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cke(cke), .odt(odt), .cmd(cmd), .banks_open(banks_open), .read_burst(read_burst),
    .in_reset(in_reset), .read_resume(read_resume), .odt_stat(odt_stat),
    .odt_enabled(odt_enabled));
`default_nettype wire

// File: dct_ctl_model.sv
// Controller model driving CKE, ODT and commands
`timescale 1ns/1ns
`default_nettype none
module dct_ctl_model
    import dct_pkg::*;
(
    input wire logic sys_clk,
    output logic cke,
    output logic odt,
    output dct_cmd_t cmd
);
    initial begin
        cke = 1'b0;
        odt = 1'b0;
        cmd = '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 14'h0};
    end
    // Unused fields toggle so stale values never look valid
    task automatic nop(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            // Alternates NOP and DESELECT
            cmd = '{~cmd.cs_n, 1'b1, 1'b1, 1'b1, ~cmd.ba, ~cmd.addr};
        end
    endtask : nop
    task automatic lm(input logic [1:0] ba, input logic [13:0] a);
        odt = 1'b0;
        cmd = '{1'b0, 1'b0, 1'b0, 1'b0, ba, a};
        nop(3);
    endtask : lm
    // Self refresh entry: REFRESH with CKE falling, all banks idle
    task automatic self_ref();
        cke = 1'b0;
        cmd = '{1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 14'h0};
        nop(1);
    endtask : self_ref
    task automatic pins(input logic c, input logic o);
        cke = c;
        odt = o;
        nop(1);
    endtask : pins
endmodule : dct_ctl_model
`default_nettype wire

// File: test_dct_cke_odt.sv
// Testbench for the CKE reset and ODT timing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module test_dct_cke_odt;
    import dct_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic banks_open = 1'b0;
    logic read_burst = 1'b0;
    logic cke, odt, in_reset, read_resume, odt_enabled;
    dct_cmd_t cmd;
    dct_odt_stat_t odt_stat;
    int errors = 0;
    int num_checks = 0;
    initial forever #4 sys_clk = ~sys_clk;
    dct_ctl_model u_ctl (.sys_clk(sys_clk), .cke(cke), .odt(odt), .cmd(cmd));
    dct_cke_odt u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cke(cke), .odt(odt),
        .cmd(cmd), .banks_open(banks_open), .read_burst(read_burst), .in_reset(in_reset),
        .read_resume(read_resume), .odt_stat(odt_stat), .odt_enabled(odt_enabled));
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic t_init();
        `CHK(in_reset, 1'b1)
        u_ctl.pins(1'b1, 1'b1);
        u_ctl.nop(3);
        `CHK(odt_stat.term_on, 1'b0)
        u_ctl.lm(2'h0, 14'h0);
        u_ctl.nop(2);
        `CHK(in_reset, 1'b0)
    endtask : t_init
    task automatic t_rtt();
        u_ctl.lm(2'h1, 14'h0040);
        u_ctl.nop(1);
        `CHK(odt_stat.rtt, 2'h2)
        `CHK(odt_enabled, 1'b1)
        u_ctl.pins(1'b1, 1'b1);
        u_ctl.nop(4);
        `CHK(odt_stat.term_on, 1'b1)
        `CHK(odt_stat.async_timing, 1'b0)
        u_ctl.pins(1'b1, 1'b0);
        u_ctl.nop(4);
    endtask : t_rtt
    // Slow exit, precharge down, then fast exit; turn-on late before entry except i == 1
    task automatic t_pd();
        for (int i = 0; i < 3; i++) begin
            u_ctl.lm(2'h0, (i == 0) ? 14'h1000 : 14'h0);
            banks_open = (i != 1);
            u_ctl.pins(1'b1, 1'b1);
            if (i == 1) u_ctl.nop(3);
            u_ctl.pins(1'b0, 1'b1);
            u_ctl.nop(2);
            `CHK(odt_stat.async_timing, 1'(i != 1))
            u_ctl.pins(1'b0, 1'b0);
            u_ctl.nop(2);
            `CHK(odt_stat.async_timing, 1'(i != 2))
            u_ctl.pins(1'b1, 1'b0);
            u_ctl.pins(1'b1, 1'b1);
            u_ctl.nop(2);
            `CHK(odt_stat.async_timing, 1'(i != 2))
            u_ctl.pins(1'b1, 1'b0);
            u_ctl.nop(2);
            `CHK(odt_stat.async_timing, 1'b1)
            u_ctl.nop(8);
            u_ctl.pins(1'b1, 1'b1);
            u_ctl.nop(2);
            `CHK(odt_stat.async_timing, 1'b0)
            u_ctl.pins(1'b1, 1'b0);
            u_ctl.nop(2);
            `CHK(odt_stat.async_timing, 1'b0)
        end
        banks_open = 1'b0;
    endtask : t_pd
    task automatic t_sref();
        u_ctl.pins(1'b1, 1'b1);
        u_ctl.nop(2);
        `CHK(odt_stat.term_on, 1'b1)
        u_ctl.self_ref();
        u_ctl.nop(2);
        `CHK(odt_stat.term_on, 1'b0)
        u_ctl.pins(1'b1, 1'b0);
        u_ctl.nop(2);
        `CHK(odt_stat.async_timing, 1'b0)
    endtask : t_sref
    task automatic t_cut();
        read_burst = 1'b1;
        u_ctl.pins(1'b0, 1'b0);
        read_burst = 1'b0;
        u_ctl.nop(2);
        `CHK(in_reset, 1'b1)
        u_ctl.pins(1'b1, 1'b0);
        `CHK(read_resume, 1'b1)
        u_ctl.nop(2);
        u_ctl.lm(2'h0, 14'h0);
        u_ctl.nop(6);
        `CHK(in_reset, 1'b0)
        `CHK(read_resume, 1'b0)
    endtask : t_cut
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_init();
        t_rtt();
        t_pd();
        t_sref();
        t_cut();
        end_of_test();
    end
    initial begin
        #20000;
        errors++;
        end_of_test();
    end
endmodule : test_dct_cke_odt
`default_nettype wire
